//--- bench/bce_flag_model.sv
// status flag register model
// written on the core clock edge
`timescale 1ns/10ps
module bce_flag_model (
   input wire logic clk_i,
   input wire logic upd_i,
   input wire bce_pkg::bce_flags_t new_i,
   output bce_pkg::bce_flags_t flags_o
);
   initial flags_o = '0;
   always @(posedge clk_i) if (upd_i) flags_o <= new_i;
endmodule

//--- bench/bce_top_properties.sv
// checker for bce_top ports
// bound into bce_top, one clock
`timescale 1ns/10ps
module bce_top_chk (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] cond_i,
   input wire logic eval_i,
   input wire bce_pkg::bce_flags_t flags_i,
   input wire logic flags_upd_i,
   input wire bce_pkg::bce_flags_t flags_new_i,
   input wire logic taken_o,
   input wire logic taken_valid_o,
   input wire bce_pkg::bce_flags_t flags_o
);
   bce_pkg::bce_flags_t f;
   logic x, s;
   assign f = flags_upd_i ? flags_new_i : flags_i;
   assign x = f.negative ^ f.overflow;
   assign s = cond_i[3] ? f.carry : cond_i[2] ? (cond_i[1] ? f.negative : f.overflow) : f.zero;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_eval_gates: assert property (!eval_i |-> !taken_o) else $error("gate");
   a_uncond_taken: assert property (eval_i && cond_i == 4'h0 |-> taken_o) else $error("uc");
   a_single_flag: assert property (eval_i && cond_i inside {[4'h2:4'h9]} |->
      taken_o == (s ^ cond_i[0])) else $error("flag");
   a_unsigned_pair: assert property (eval_i && cond_i[3:1] == 3'h7 |->
      taken_o == ((f.zero | f.carry) == cond_i[0])) else $error("uns");
   a_signed_pair: assert property (eval_i && cond_i[3:1] == 3'h6 |->
      taken_o == (x != cond_i[0])) else $error("sgn");
   a_sle_pair: assert property (eval_i && cond_i[3:1] == 3'h5 |->
      taken_o == ((f.zero | x) == cond_i[0])) else $error("sle");
   a_table_end: assert property (eval_i && cond_i == 4'h1 |->
      taken_o == !(f.zero | f.table_end)) else $error("net");
   a_flags_track: assert property ($past(resetn_i, 4) |-> flags_o == $past(f)) else $error("fl");
endmodule
bind bce_top bce_top_chk i_bce_top_chk (
   .clk_i(clk_i),
   .resetn_i(resetn_i),
   .cond_i(cond_i),
   .eval_i(eval_i),
   .flags_i(flags_i),
   .flags_upd_i(flags_upd_i),
   .flags_new_i(flags_new_i),
   .taken_o(taken_o),
   .taken_valid_o(taken_valid_o),
   .flags_o(flags_o)
);

//--- bench/tb_bce_top.sv
// bench for bce_top
// inputs change at the falling edge
`timescale 1ns/10ps
module tb_bce_top;
   logic clk_i = 0, resetn_i = 0, eval_i = 0, flags_upd_i = 0, taken_o, taken_valid_o;
   logic [3:0] cond_i = '0;
   bce_pkg::bce_flags_t flags_new_i = '0, flags_i, flags_o;
   int err_total = 0, n_compared = 0;
   bce_top i_bce_top (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .cond_i(cond_i),
      .eval_i(eval_i),
      .flags_i(flags_i),
      .flags_upd_i(flags_upd_i),
      .flags_new_i(flags_new_i),
      .taken_o(taken_o),
      .taken_valid_o(taken_valid_o),
      .flags_o(flags_o)
   );
   bce_flag_model i_bce_flag_model (
      .clk_i(clk_i),
      .upd_i(flags_upd_i),
      .new_i(flags_new_i),
      .flags_o(flags_i)
   );
   initial forever #4 clk_i = ~clk_i;
   task chk(input string w, input logic [4:0] s, e);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] %s exp %h seen %h", w, e, s);
      end
   endtask
   task give_verdict;
      if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic ex(input logic [3:0] c, input logic [4:0] f);
      logic [15:0] t;
      t = {f[0] | f[2], ~(f[0] | f[2]), ~(f[3] ^ f[1]), f[3] ^ f[1], f[0] | (f[3] ^ f[1]),
         ~(f[0] | (f[3] ^ f[1])), ~f[2], f[2], ~f[3], f[3], ~f[1], f[1], ~f[0], f[0],
         ~(f[0] | f[4]), 1'b1};
      return t[c];
   endfunction
   task sweep;
      for (int f = 0; f < 32; f++) begin
         @(negedge clk_i) {flags_upd_i, eval_i, cond_i, flags_new_i} = {2'h3, f[3:0], f[4:0]};
         #1 chk("fwd", taken_o, ex(cond_i, flags_new_i));
         chk("valid", taken_valid_o, 5'h1);
         for (int c = 0; c < 16; c++) begin
            @(negedge clk_i) {flags_upd_i, cond_i} = {1'h0, c[3:0]};
            #1 chk("taken", taken_o, ex(cond_i, flags_new_i));
         end
         chk("flags", flags_o, f[4:0]);
      end
   endtask
   task gate;
      @(negedge clk_i) {eval_i, cond_i} = 5'h0;
      #1 chk("idle", {taken_o, taken_valid_o}, 5'h0);
   endtask
   task rst_mid;
      @(negedge clk_i) resetn_i = 0;
      #1 chk("rst_mid", flags_o, 5'h0);
      repeat (6) @(negedge clk_i);
      resetn_i = 1;
      repeat (3) @(negedge clk_i);
      chk("rst_rel", flags_o, 5'h1f);
   endtask
   initial begin
      repeat (6) @(negedge clk_i);
      chk("rst", flags_o, 5'h0);
      resetn_i = 1;
      repeat (3) @(negedge clk_i);
      sweep;
      gate;
      rst_mid;
      give_verdict;
   end
   initial begin
      #20us;
      err_total++;
      give_verdict;
   end
endmodule

//--- hdl/bce_decode.sv
// combinational condition test for one selector and one flag set
// assumes flags are already current for the branch being resolved
`timescale 1ns/10ps
module bce_decode (
   input wire logic [3:0] cond_i,
   input wire bce_pkg::bce_flags_t flags_i,
   output logic taken_o
);

   logic sgn_lt;
   logic sgn_le;
   logic uns_le;

   assign sgn_lt = flags_i.negative ^ flags_i.overflow;
   assign sgn_le = flags_i.zero | sgn_lt;
   assign uns_le = flags_i.zero | flags_i.carry;

   // ==========================================================
   // selector decode, one test each
   always_comb begin
      case (bce_pkg::bce_cond_t'(cond_i)) // RL1
         bce_pkg::always_true_code: taken_o = 1'h1; // RL2
         bce_pkg::unequal_not_table_end_code: taken_o = ~(flags_i.zero | flags_i.table_end); // RL7
         bce_pkg::zero_set_code: taken_o = flags_i.zero; // RL3
         bce_pkg::zero_clear_code: taken_o = ~flags_i.zero; // RL3
         bce_pkg::overflow_set_code: taken_o = flags_i.overflow; // RL3
         bce_pkg::overflow_clear_code: taken_o = ~flags_i.overflow; // RL3
         bce_pkg::negative_set_code: taken_o = flags_i.negative; // RL3
         bce_pkg::negative_clear_code: taken_o = ~flags_i.negative; // RL3
         bce_pkg::carry_set_code: taken_o = flags_i.carry; // RL3
         bce_pkg::carry_clear_code: taken_o = ~flags_i.carry; // RL3
         bce_pkg::signed_greater_code: taken_o = ~sgn_le; // RL6
         bce_pkg::signed_less_equal_code: taken_o = sgn_le; // RL6
         bce_pkg::signed_less_code: taken_o = sgn_lt; // RL5
         bce_pkg::signed_ge_code: taken_o = ~sgn_lt; // RL5
         bce_pkg::unsigned_higher_code: taken_o = ~uns_le; // RL4
         bce_pkg::unsigned_lower_same_code: taken_o = uns_le; // RL4
         default: taken_o = 1'h0;
      endcase
   end

endmodule

//--- hdl/bce_pkg.sv
// package for the branch condition evaluator
// assumes a single core clock domain; no bus, plain ports only
package bce_pkg;

   // ==========================================================
   // widths
   localparam int unsigned COND_W = 4;
   localparam int unsigned COND_COUNT = 16;

   // ==========================================================
   // condition selector encodings
   typedef enum logic [3:0] {
      always_true_code = 4'h0,
      unequal_not_table_end_code = 4'h1,
      zero_set_code = 4'h2,
      zero_clear_code = 4'h3,
      overflow_set_code = 4'h4,
      overflow_clear_code = 4'h5,
      negative_set_code = 4'h6,
      negative_clear_code = 4'h7,
      carry_set_code = 4'h8,
      carry_clear_code = 4'h9,
      signed_greater_code = 4'ha,
      signed_less_equal_code = 4'hb,
      signed_less_code = 4'hc,
      signed_ge_code = 4'hd,
      unsigned_higher_code = 4'he,
      unsigned_lower_same_code = 4'hf
   } bce_cond_t;

   // ==========================================================
   // status flags as delivered by the flag register
   typedef struct packed {
      logic table_end;
      logic negative;
      logic carry;
      logic overflow;
      logic zero;
   } bce_flags_t;

   localparam bce_flags_t FLAGS_RESET = '{default: 1'h0};

endpackage

//--- hdl/bce_top.sv
// branch condition evaluator top: flag forwarding and condition test
// assumes decode stage and flag register share clk_i
// Summary of operation
// RL1 - four-bit selector, sixteen distinct tests
// RL2 - taken only when test true; 0h always
// RL3 - 2h-9h test single flags set/clear
// RL4 - Fh zero or carry; Eh both clear
// RL5 - Ch N xor V; Dh N equals V
// RL6 - Bh Z or N xor V; Ah inverse
// RL7 - 1h zero and table-end both clear
// RL8 - use flags from latest completed update
`timescale 1ns/10ps
module bce_top (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] cond_i,
   input wire logic eval_i,
   input wire bce_pkg::bce_flags_t flags_i,
   input wire logic flags_upd_i,
   input wire bce_pkg::bce_flags_t flags_new_i,
   output logic taken_o,
   output logic taken_valid_o,
   output bce_pkg::bce_flags_t flags_o
);

   // ==========================================================
   // local sizes
   // all taken from the package so a wider flag word only has to be changed
   // in one place; the selector width is also written out in the cond_i ports
   localparam int unsigned FLAG_W = $bits(bce_pkg::bce_flags_t);
   localparam int unsigned SEL_W = bce_pkg::COND_W;
   localparam int unsigned SEL_COUNT = bce_pkg::COND_COUNT;
   localparam logic [FLAG_W-1:0] FLAGS_RESET_VEC = bce_pkg::FLAGS_RESET;

   // ==========================================================
   // helpers
   // flag struct seen as a flat vector, table_end in the top bit
   function automatic logic [FLAG_W-1:0] flags_flat(
      input bce_pkg::bce_flags_t f
   );
      flags_flat = f;
   endfunction

   // flat vector seen as a flag struct again
   function automatic bce_pkg::bce_flags_t flags_pack(
      input logic [FLAG_W-1:0] v
   );
      flags_pack = v;
   endfunction

   // constant selector code of one lane
   function automatic logic [SEL_W-1:0] lane_code(
      input int unsigned lane
   );
      lane_code = SEL_W'(lane);
   endfunction

   // selector to a one-hot lane pick
   function automatic logic [SEL_COUNT-1:0] sel_onehot(
      input logic [SEL_W-1:0] sel
   );
      sel_onehot = '0;
      sel_onehot[sel] = 1'h1;
   endfunction

   // ==========================================================
   // reset release
   // asserted at once, released through two flops on clk_i
   // only the flag register hangs on this copy; the test path has no state
   logic rstn_meta_reg;
   logic rstn_sync_reg;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rstn_meta_reg <= 1'h0;
      end else begin
         rstn_meta_reg <= 1'h1;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rstn_sync_reg <= 1'h0;
      end else begin
         rstn_sync_reg <= rstn_meta_reg;
      end
   end

   // ==========================================================
   // flag inputs as flat vectors
   logic [FLAG_W-1:0] flags_cur_vec;
   logic [FLAG_W-1:0] flags_wr_vec;

   assign flags_cur_vec = flags_flat(flags_i);
   assign flags_wr_vec = flags_flat(flags_new_i);

   // ==========================================================
   // flag forwarding
   // an update completing this cycle bypasses the flag register,
   // so a branch right behind it never tests stale status
   logic [FLAG_W-1:0] flags_eff_vec;
   bce_pkg::bce_flags_t flags_eff;

   for (genvar b = 0; b < FLAG_W; b++) begin : g_fwd
      assign flags_eff_vec[b] = flags_upd_i ? flags_wr_vec[b] : flags_cur_vec[b]; // RL8
   end

   assign flags_eff = flags_pack(flags_eff_vec);

   // ==========================================================
   // flag register: effective flags, one cycle later
   // gives the branch unit the status that the last test saw
   logic [FLAG_W-1:0] flags_reg;

   always_ff @(posedge clk_i or negedge rstn_sync_reg) begin
      if (!rstn_sync_reg) begin
         flags_reg <= FLAGS_RESET_VEC;
      end else begin
         flags_reg <= flags_eff_vec; // RL8
      end
   end

   assign flags_o = flags_pack(flags_reg);

   // ==========================================================
   // condition lanes
   // every test is worked out in parallel on the forwarded flags,
   // which keeps a late selector off the long flag path
   logic [SEL_COUNT-1:0] lane_taken;

   for (genvar i = 0; i < SEL_COUNT; i++) begin : g_lane
      localparam logic [SEL_W-1:0] LANE_SEL = lane_code(i);
      logic lane_test;

      bce_decode i_bce_decode (
         .cond_i(LANE_SEL),
         .flags_i(flags_eff),
         .taken_o(lane_test)
      );

      assign lane_taken[i] = lane_test;
   end

   // ==========================================================
   // lane pick
   // exactly one lane is picked for any selector value
   logic [SEL_COUNT-1:0] sel_hot;
   logic hit;

   assign sel_hot = sel_onehot(cond_i); // RL1

   always_comb begin
      hit = 1'h0;
      for (int i = 0; i < SEL_COUNT; i++) begin
         if (sel_hot[i]) begin
            hit = lane_taken[i];
         end
      end
   end

   // ==========================================================
   // outputs
   // no evaluation this cycle means no branch, whatever the selector
   assign taken_o = eval_i & hit; // RL2
   assign taken_valid_o = eval_i;

endmodule
